// File: ssra_slave.v
`timescale 1ns/100ps
`default_nettype none
`include "ssra_defs.vh"
module ssra_slave #(
  parameter        IDX_W    = 6,
  parameter [15:0] FREQ_MAX = 16'hFFFF,
  parameter [15:0] SRC_MAX  = 16'h0008,
  parameter [15:0] DI_MAX   = 16'h00FF,
  parameter        DI_NUM   = 5
) (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        req_valid_in,
  input  wire [7:0]  req_func_in,
  input  wire [15:0] req_addr_in,
  input  wire        req_write_in,
  input  wire [15:0] req_wdata_in,
  input  wire [15:0] req_count_in,
  input  wire        user_lock_in,
  input  wire        maker_write_en_in,
  input  wire        drive_running_in,
  input  wire [7:0]  state_flags_in,
  input  wire [4:0]  fault_code_in,
  output reg         rsp_valid_out,
  output reg  [7:0]  rsp_func_out,
  output reg         rsp_exc_out,
  output reg  [7:0]  rsp_code_out,
  output reg  [15:0] rsp_data_out,
  output reg         cmd_strobe_out,
  output reg         cmd_run_out,
  output reg         cmd_jog_out,
  output reg         cmd_reverse_out,
  output reg         cmd_stop_out,
  output reg         cmd_estop_out,
  output reg         cmd_fault_reset_out,
  output reg         cmd_ramp_hold_out,
  output reg         cmd_active_out,
  output reg  [15:0] freq_set_out,
  output reg         freq_update_out
);

  wire [7:0] grp = req_addr_in[15:8]; // RULE12
  wire [7:0] idx = req_addr_in[7:0]; // RULE12

  wire func_ok = (req_func_in == `SSRA_FN_READ) || (req_func_in == `SSRA_FN_WRITE1) ||
                 (req_func_in == `SSRA_FN_DIAG) || (req_func_in == `SSRA_FN_WRITEN) ||
                 (req_func_in == `SSRA_FN_RDWR); // RULE2

  wire idx_ok   = (idx >> IDX_W) == 8'h00;
  wire is_param = (grp <= `SSRA_GRP_MONITOR) && (grp != `SSRA_GRP_RSVD) && idx_ok; // RULE13
  wire is_cmd   = (req_addr_in == `SSRA_ADDR_CMD);
  wire is_freq  = (req_addr_in == `SSRA_ADDR_FREQ);
  wire is_state = (req_addr_in == `SSRA_ADDR_STATE);

  wire is_b0      = is_param && (grp == `SSRA_GRP_B0);
  wire is_user_pw = is_b0 && (idx == `SSRA_IDX_USER_PW);
  wire is_pw      = is_user_pw || (is_b0 && (idx == `SSRA_IDX_MAKER_PW));
  wire fn6_only   = is_pw || (is_b0 && (idx == `SSRA_IDX_INIT));
  wire forbidden  = (is_b0 && ((idx == `SSRA_IDX_COPY) || (idx == `SSRA_IDX_RUN_DISP) ||
                    (idx == `SSRA_IDX_STOP_DISP))) ||
                    (is_param && (grp == `SSRA_GRP_S2) && (idx == `SSRA_IDX_PHYS_CALC));
  wire is_src     = is_param && (grp == `SSRA_GRP_B1) && (idx == `SSRA_IDX_FREQ_SRC);
  wire is_fault   = is_param && (grp == `SSRA_GRP_E4) && (idx == `SSRA_IDX_FAULT);
  // Motor data groups are the ones held still while the drive turns.
  wire run_locked = is_param && ((grp == `SSRA_GRP_S0) || (grp == `SSRA_GRP_S2) ||
                    (grp == `SSRA_GRP_S3));

  // Digital input assignment shadows, kept so a duplicate can be spotted in one cycle.
  wire              mem_we;
  wire [DI_NUM-1:0] di_sel;
  wire [DI_NUM-1:0] di_clash;
  wire              is_di  = |di_sel;
  wire              di_dup = |di_clash;
  genvar g;
  generate
    for (g = 0; g < DI_NUM; g = g + 1) begin : g_di
      reg [15:0] di_q;
      assign di_sel[g]   = is_param && (grp == `SSRA_GRP_E0) &&
                           ({24'h000000, idx} == `SSRA_IDX_DI_FIRST + g);
      assign di_clash[g] = !di_sel[g] && (req_wdata_in != 16'h0000) &&
                           (di_q == req_wdata_in); // RULE10
      always @(posedge clk_in) begin
        if (rst_in) begin
          di_q <= 16'h0000;
        end else if (mem_we && di_sel[g]) begin
          di_q <= req_wdata_in;
        end
      end
    end
  endgenerate

  reg [15:0] src_q;
  reg [7:0]  code_d;
  reg [2:0]  kind_d;

  // Checks run in a fixed order so exactly one code is reported.
  always @* begin
    code_d = `SSRA_EXC_NONE; // RULE26
    kind_d = `SSRA_KIND_MEM;
    if (!func_ok) begin
      code_d = `SSRA_EXC_FUNC; // RULE2
    end else if (req_func_in == `SSRA_FN_DIAG) begin
      kind_d = `SSRA_KIND_ECHO;
    end else if ((req_func_in == `SSRA_FN_READ) && (req_count_in > `SSRA_READ_MAX)) begin
      code_d = `SSRA_EXC_RANGE; // RULE11
    end else if (!req_write_in) begin
      if (is_state) begin
        kind_d = `SSRA_KIND_STATE; // RULE24
      end else if (is_freq) begin
        kind_d = `SSRA_KIND_FREQ;
      end else if (is_pw) begin
        kind_d = `SSRA_KIND_ZERO; // RULE23
      end else if (is_fault) begin
        kind_d = `SSRA_KIND_FAULT;
      end else if (!is_param) begin
        code_d = `SSRA_EXC_ADDR; // RULE4
      end
    end else begin
      if (!(is_param || is_cmd || is_freq || is_state)) begin
        code_d = `SSRA_EXC_ADDR; // RULE4
      end else if (is_state || (is_param && (grp == `SSRA_GRP_MONITOR))) begin
        code_d = `SSRA_EXC_READONLY; // RULE7 RULE15
      end else if (forbidden) begin
        code_d = `SSRA_EXC_INVALID; // RULE8
      end else if (fn6_only && (req_func_in != `SSRA_FN_WRITE1)) begin
        code_d = `SSRA_EXC_INVALID; // RULE9
      end else if (is_param && (grp == `SSRA_GRP_MAKER) && !maker_write_en_in) begin
        code_d = `SSRA_EXC_LOCKED; // RULE14
      end else if (is_param && user_lock_in && !is_user_pw) begin
        code_d = `SSRA_EXC_LOCKED; // RULE3 RULE24
      end else if (run_locked && drive_running_in) begin
        code_d = `SSRA_EXC_RUNNING; // RULE6
      end else if ((is_freq && (req_wdata_in > FREQ_MAX)) ||
                   (is_src && (req_wdata_in > SRC_MAX)) ||
                   (is_di && (req_wdata_in > DI_MAX))) begin
        code_d = `SSRA_EXC_VALUE; // RULE5
      end else if (is_di && di_dup) begin
        code_d = `SSRA_EXC_INVALID; // RULE10
      end
    end
  end

  wire good   = req_valid_in && (code_d == `SSRA_EXC_NONE);
  wire wr_ok  = good && req_write_in && (req_func_in != `SSRA_FN_DIAG);
  assign mem_we = wr_ok && is_param;

  wire [15:0] ram_q;
  ssra_param_ram #(
    .AW (IDX_W + 4),
    .DW (16)
  ) u_ram (
    .clk_in    (clk_in),
    .we_in     (mem_we),
    .addr_in   ({grp[3:0], idx[IDX_W-1:0]}),
    .wdata_in  (req_wdata_in),
    .rdata_out (ram_q)
  );

  reg        s1_valid_q;
  reg [7:0]  s1_func_q;
  reg [7:0]  s1_code_q;
  reg [2:0]  s1_kind_q;
  reg [15:0] s1_echo_q;
  reg [15:0] rdata_d;

  always @* begin
    case (s1_kind_q)
      `SSRA_KIND_ZERO:  rdata_d = 16'h0000;
      `SSRA_KIND_FREQ:  rdata_d = freq_set_out;
      `SSRA_KIND_STATE: rdata_d = {fault_code_in, 3'h0, state_flags_in}; // RULE21 RULE22 RULE25
      `SSRA_KIND_FAULT: rdata_d = {11'h000, fault_code_in};
      `SSRA_KIND_ECHO:  rdata_d = s1_echo_q;
      default:          rdata_d = ram_q;
    endcase
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      s1_valid_q    <= 1'b0;
      s1_func_q     <= 8'h00;
      s1_code_q     <= 8'h00;
      s1_kind_q     <= `SSRA_KIND_MEM;
      s1_echo_q     <= 16'h0000;
      rsp_valid_out <= 1'b0;
      rsp_func_out  <= 8'h00;
      rsp_exc_out   <= 1'b0;
      rsp_code_out  <= 8'h00;
      rsp_data_out  <= 16'h0000;
    end else begin
      s1_valid_q    <= req_valid_in;
      s1_func_q     <= req_func_in;
      s1_code_q     <= code_d;
      s1_kind_q     <= kind_d;
      s1_echo_q     <= req_wdata_in;
      rsp_valid_out <= s1_valid_q;
      rsp_exc_out   <= (s1_code_q != `SSRA_EXC_NONE);
      rsp_code_out  <= s1_code_q;
      if (s1_code_q != `SSRA_EXC_NONE) begin
        rsp_func_out <= s1_func_q | `SSRA_EXC_FLAG; // RULE1
        rsp_data_out <= 16'h0000;
      end else begin
        rsp_func_out <= s1_func_q;
        rsp_data_out <= rdata_d;
      end
    end
  end

  // The command bits are passed on as written; conflicts are the run logic's business.
  always @(posedge clk_in) begin
    if (rst_in) begin
      cmd_strobe_out      <= 1'b0;
      cmd_run_out         <= 1'b0;
      cmd_jog_out         <= 1'b0;
      cmd_reverse_out     <= 1'b0;
      cmd_stop_out        <= 1'b0;
      cmd_estop_out       <= 1'b0;
      cmd_fault_reset_out <= 1'b0;
      cmd_ramp_hold_out   <= 1'b0;
      cmd_active_out      <= 1'b0;
    end else begin
      cmd_strobe_out <= wr_ok && is_cmd; // RULE16 RULE20
      if (wr_ok && is_cmd) begin
        cmd_run_out         <= req_wdata_in[`SSRA_CMD_RUN]; // RULE17
        cmd_jog_out         <= req_wdata_in[`SSRA_CMD_JOG]; // RULE17
        cmd_reverse_out     <= req_wdata_in[`SSRA_CMD_REV]; // RULE17
        cmd_active_out      <= req_wdata_in[`SSRA_CMD_ACTIVE]; // RULE17 RULE25
        cmd_stop_out        <= req_wdata_in[`SSRA_CMD_STOP]; // RULE18
        cmd_estop_out       <= req_wdata_in[`SSRA_CMD_ESTOP]; // RULE18
        cmd_fault_reset_out <= req_wdata_in[`SSRA_CMD_RESET]; // RULE18
        cmd_ramp_hold_out   <= req_wdata_in[`SSRA_CMD_HOLD]; // RULE18
      end
    end
  end

  // A setpoint written while the source is elsewhere is acknowledged but not applied.
  always @(posedge clk_in) begin
    if (rst_in) begin
      src_q           <= 16'h0000;
      freq_set_out    <= 16'h0000;
      freq_update_out <= 1'b0;
    end else begin
      if (mem_we && is_src) begin
        src_q <= req_wdata_in;
      end
      freq_update_out <= wr_ok && is_freq && (src_q == `SSRA_FREQ_SRC_LINK); // RULE19
      if (wr_ok && is_freq && (src_q == `SSRA_FREQ_SRC_LINK)) begin
        freq_set_out <= req_wdata_in; // RULE19
      end
    end
  end

endmodule
`default_nettype wire

// File: ssra_defs.vh
// Behaviour
// RULE1: Exception reply sets function code top bit.
// RULE2: Unknown function code answers exception code 2.
// RULE3: Write blocked by user lock answers 1.
// RULE4: Unimplemented register address answers exception 3.
// RULE5: Out-of-range write value answers exception 4.
// RULE6: Run-locked parameter written while running answers 5.
// RULE7: Write to read-only parameter answers 6.
// RULE8: Forbidden parameter writes answer exception 7.
// RULE9: Password and initialise writes need function 6.
// RULE10: Duplicate nonzero digital input assignment refused.
// RULE11: Read of over sixteen registers answers B.
// RULE12: Address upper byte group, lower byte index.
// RULE13: Groups 0x00 to 0x0D, 0x03 reserved.
// RULE14: Manufacturer group readable, writable only if permitted.
// RULE15: Monitoring group is always write protected.
// RULE16: Write-only command word at 0x4000.
// RULE17: Command bits run, jog, reverse, active.
// RULE18: Command bits stop, e-stop, reset, ramp hold.
// RULE19: Setpoint at 0x4001 applies only with source 5.
// RULE20: Command word accepted unconditionally after good CRC.
// RULE21: Read-only state word at 0x5000 flags.
// RULE22: State word top five bits report fault code.
// RULE23: Password parameters always read back as zero.
// RULE24: User lock never blocks command or state.
// RULE25: Reserved bits read zero, ignored on write.
// RULE26: Fixed priority: function, address, permission, value.
`ifndef SSRA_DEFS_VH
`define SSRA_DEFS_VH

`define SSRA_FN_READ        8'h03
`define SSRA_FN_WRITE1      8'h06
`define SSRA_FN_DIAG        8'h08
`define SSRA_FN_WRITEN      8'h10
`define SSRA_FN_RDWR        8'h17
`define SSRA_EXC_FLAG       8'h80

`define SSRA_EXC_NONE       8'h00
`define SSRA_EXC_LOCKED     8'h01
`define SSRA_EXC_FUNC       8'h02
`define SSRA_EXC_ADDR       8'h03
`define SSRA_EXC_VALUE      8'h04
`define SSRA_EXC_RUNNING    8'h05
`define SSRA_EXC_READONLY   8'h06
`define SSRA_EXC_INVALID    8'h07
`define SSRA_EXC_RANGE      8'h0B
`define SSRA_READ_MAX       16'h0010

`define SSRA_ADDR_CMD       16'h4000
`define SSRA_ADDR_FREQ      16'h4001
`define SSRA_ADDR_STATE     16'h5000

`define SSRA_GRP_B0         8'h00
`define SSRA_GRP_B1         8'h01
`define SSRA_GRP_S0         8'h02
`define SSRA_GRP_RSVD       8'h03
`define SSRA_GRP_S2         8'h04
`define SSRA_GRP_S3         8'h05
`define SSRA_GRP_E0         8'h06
`define SSRA_GRP_E4         8'h0A
`define SSRA_GRP_MAKER      8'h0C
`define SSRA_GRP_MONITOR    8'h0D

`define SSRA_IDX_USER_PW    8'h00
`define SSRA_IDX_MAKER_PW   8'h01
`define SSRA_IDX_INIT       8'h05
`define SSRA_IDX_COPY       8'h06
`define SSRA_IDX_RUN_DISP   8'h1E
`define SSRA_IDX_STOP_DISP  8'h1F
`define SSRA_IDX_PHYS_CALC  8'h0F
`define SSRA_IDX_FREQ_SRC   8'h00
`define SSRA_IDX_FAULT      8'h14
`define SSRA_IDX_DI_FIRST   8'h01
`define SSRA_FREQ_SRC_LINK  16'h0005

`define SSRA_CMD_RUN        0
`define SSRA_CMD_JOG        1
`define SSRA_CMD_REV        2
`define SSRA_CMD_STOP       3
`define SSRA_CMD_ESTOP      4
`define SSRA_CMD_RESET      5
`define SSRA_CMD_HOLD       6
`define SSRA_CMD_ACTIVE     7

`define SSRA_KIND_MEM       3'h0
`define SSRA_KIND_ZERO      3'h1
`define SSRA_KIND_FREQ      3'h2
`define SSRA_KIND_STATE     3'h3
`define SSRA_KIND_FAULT     3'h4
`define SSRA_KIND_ECHO      3'h5

`endif

// File: ssra_param_ram.v
`timescale 1ns/100ps
`default_nettype none
module ssra_param_ram #(
  parameter AW = 10,
  parameter DW = 16
) (
  input  wire          clk_in,
  input  wire          we_in,
  input  wire [AW-1:0] addr_in,
  input  wire [DW-1:0] wdata_in,
  output reg  [DW-1:0] rdata_out
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Read-first: a write returns the old word on the same edge.
  always @(posedge clk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
    rdata_out <= mem[addr_in];
  end

endmodule
`default_nettype wire

// File: ssra_slave_properties.sv
`timescale 1ns/100ps
`default_nettype none
module ssra_slave_properties (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        req_valid_in,
  input wire logic        req_write_in,
  input wire logic [7:0]  req_func_in,
  input wire logic [7:0]  state_flags_in,
  input wire logic [7:0]  rsp_func_out,
  input wire logic [7:0]  rsp_code_out,
  input wire logic [15:0] req_addr_in,
  input wire logic [15:0] req_wdata_in,
  input wire logic [15:0] req_count_in,
  input wire logic [15:0] rsp_data_out,
  input wire logic [4:0]  fault_code_in,
  input wire logic        rsp_valid_out,
  input wire logic        rsp_exc_out,
  input wire logic        cmd_strobe_out,
  input wire logic        cmd_run_out,
  input wire logic        cmd_stop_out,
  input wire logic        cmd_active_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire       w6 = req_valid_in && req_func_in == 8'h06 && req_write_in;
  wire       rd = req_valid_in && req_func_in == 8'h03 && !req_write_in
                  && req_count_in <= 16'h0010;
  wire [2:0] kb = {req_wdata_in[7], req_wdata_in[3], req_wdata_in[0]};
  chk_func_byte: assert property (req_valid_in |-> ##2 rsp_valid_out &&
    rsp_func_out == ($past(req_func_in, 2) | (rsp_exc_out ? 8'h80 : 8'h00)))
    else $error("answer function byte wrong");
  chk_exc_flag: assert property (rsp_valid_out |-> rsp_exc_out == (rsp_code_out != 8'h00))
    else $error("exception flag and code disagree");
  chk_bad_func: assert property (req_valid_in &&
    !(req_func_in inside {8'h03, 8'h06, 8'h08, 8'h10, 8'h17}) |-> ##2 rsp_code_out == 8'h02)
    else $error("unknown function not refused");
  chk_read_range: assert property (req_valid_in && req_func_in == 8'h03 &&
    req_count_in > 16'h0010 |-> ##2 rsp_code_out == 8'h0B) else $error("long read not refused");
  chk_rsvd_group: assert property (w6 && req_addr_in[15:8] == 8'h03
    |-> ##2 rsp_code_out == 8'h03) else $error("reserved group not refused");
  chk_monitor_wp: assert property (w6 && req_addr_in[15:6] == 10'h034
    |-> ##2 rsp_code_out == 8'h06) else $error("monitoring write not refused");
  chk_forbid_write: assert property (w6 &&
    req_addr_in inside {16'h0006, 16'h001E, 16'h001F, 16'h040F} |-> ##2 rsp_code_out == 8'h07)
    else $error("forbidden write not refused");
  chk_cmd_accept: assert property (w6 && req_addr_in == 16'h4000 |=> cmd_strobe_out &&
    {cmd_active_out, cmd_stop_out, cmd_run_out} == $past(kb) ##1 rsp_code_out == 8'h00)
    else $error("command word not taken");
  chk_state_word: assert property (rd && req_addr_in == 16'h5000 |-> ##2
    rsp_data_out == {$past(fault_code_in), 3'h0, $past(state_flags_in)})
    else $error("state word wrong");
  chk_pw_zero: assert property (rd && req_addr_in[15:1] == 15'h0000
    |-> ##2 !rsp_exc_out && rsp_data_out == 16'h0000) else $error("password not masked");
  cover property (rsp_valid_out && rsp_code_out == 8'h07);
  cover property (cmd_strobe_out);
  cover property (rsp_valid_out && rsp_code_out == 8'h05);
endmodule
bind ssra_slave ssra_slave_properties u_chk (.clk_in, .rst_in, .req_valid_in, .req_write_in,
  .req_func_in, .state_flags_in, .rsp_func_out, .rsp_code_out, .req_addr_in, .req_wdata_in,
  .req_count_in, .rsp_data_out, .fault_code_in, .rsp_valid_out, .rsp_exc_out,
  .cmd_strobe_out, .cmd_run_out, .cmd_stop_out, .cmd_active_out);
`default_nettype wire

// File: ssra_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module ssra_master_model (
  input  wire logic        clk_in,
  output var  logic        valid_out,
  output var  logic        write_out,
  output var  logic [7:0]  func_out,
  output var  logic [15:0] addr_out,
  output var  logic [15:0] wdata_out,
  output var  logic [15:0] count_out
);
  initial {valid_out, write_out, func_out, addr_out, wdata_out, count_out} = '0;
  // Password writes use function 6 except where a test wants the refusal.
  task send(input logic [7:0] f, input logic [15:0] a, input logic w, input logic [15:0] d, n);
    valid_out <= 1'b1;
    {func_out, addr_out, write_out, wdata_out, count_out} <= {f, a, w, d, n};
    @(posedge clk_in);
  endtask
  // Idle function, address, write and data fields flip every cycle (count holds) so a stale request is never mistaken for a live one.
  task idle();
    valid_out <= 1'b0;
    {func_out, addr_out, write_out, wdata_out} <= ~{func_out, addr_out, write_out, wdata_out};
    @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_in = 1'b0, rst_in = 1'b1, lock = 1'b0, mk = 1'b0, run = 1'b0;
  logic [7:0] flags = 8'h00, f, rf, rc;
  logic [4:0] fault = 5'h00;
  logic v, w, rv, rx, cs, fu;
  logic [7:0] c;
  logic [15:0] a, d, n, rd, fs, freq, cmdw;
  int failures = 0, tests_run = 0, src, k;
  int upd_exp = 0, upd_seen = 0, cmd_exp = 0, cmd_seen = 0;
  int di [1:5];
  logic [15:0] mem [int];
  logic [32:0] eq [$], e;
  logic [7:0]  fw [4] = '{8'h03, 8'h17, 8'h06, 8'h10};
  logic [15:0] pool [15] = '{16'h0000, 16'h0001, 16'h0100, 16'h0200, 16'h0410, 16'h0601,
    16'h0602, 16'h0603, 16'h0604, 16'h0605, 16'h0C02, 16'h4000, 16'h4001, 16'h5000, 16'h0A14};
  logic [23:0] bad [11] = '{24'h060300, 24'h100E00, 24'h060040, 24'h060D10, 24'h060006,
    24'h06001E, 24'h10001F, 24'h06040F, 24'h100005, 24'h100000, 24'h065000};
  ssra_master_model u_mst (.clk_in(clk_in), .valid_out(v), .write_out(w), .func_out(f),
    .addr_out(a), .wdata_out(d), .count_out(n));
  ssra_slave u_dut (.clk_in(clk_in), .rst_in(rst_in), .req_valid_in(v), .req_func_in(f),
    .req_addr_in(a), .req_write_in(w), .req_wdata_in(d), .req_count_in(n),
    .user_lock_in(lock), .maker_write_en_in(mk), .drive_running_in(run),
    .state_flags_in(flags), .fault_code_in(fault), .rsp_valid_out(rv), .rsp_func_out(rf),
    .rsp_exc_out(rx), .rsp_code_out(rc), .rsp_data_out(rd), .cmd_strobe_out(cs),
    .cmd_run_out(c[0]), .cmd_jog_out(c[1]), .cmd_reverse_out(c[2]), .cmd_stop_out(c[3]),
    .cmd_estop_out(c[4]), .cmd_fault_reset_out(c[5]), .cmd_ramp_hold_out(c[6]),
    .cmd_active_out(c[7]), .freq_set_out(fs), .freq_update_out(fu));
  initial forever #4 clk_in = ~clk_in;
  task automatic check(input string nm, input logic [15:0] ex, got);
    tests_run++;
    if (got !== ex) begin
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
      failures++;
    end
  endtask
  function automatic logic [32:0] model(input logic [7:0] fn, input logic [15:0] ad,
                                        input logic wr, input logic [15:0] dt, nn);
    logic [7:0]  g, i, x;
    logic [15:0] q;
    logic        fl;
    {g, i, x, q, fl} = {ad, 8'h00, 16'h0000, 1'b1};
    if (!(fn inside {8'h03, 8'h06, 8'h08, 8'h10, 8'h17})) x = 8'h02;
    else if (fn == 8'h08) q = dt;
    else if (fn == 8'h03 && nn > 16'h0010) x = 8'h0B;
    else if (ad == 16'h4000) begin
      if (!wr) x = 8'h03;
      else begin
        cmdw = dt;
        cmd_exp++;
        fl = 1'b0;
      end
    end else if (ad == 16'h4001) begin
      if (!wr) q = freq;
      else fl = 1'b0;
      if (wr && src == 5) begin
        freq = dt;
        upd_exp++;
      end
    end else if (ad == 16'h5000) begin
      if (wr) x = 8'h06;
      else q = {fault, 3'h0, flags};
    end else if (g == 8'h03 || g > 8'h0D || i > 8'h3F) x = 8'h03;
    else if (!wr && ad == 16'h0A14) q = {11'h000, fault};
    else if (!wr) q = (g == 8'h00 && i < 8'h02) ? 16'h0000 : mem[ad];
    else begin
      fl = 1'b0;
      if (g == 8'h0D) x = 8'h06;
      else if (ad inside {16'h0006, 16'h001E, 16'h001F, 16'h040F}) x = 8'h07;
      else if (ad inside {16'h0000, 16'h0001, 16'h0005} && fn != 8'h06) x = 8'h07;
      else if (g == 8'h0C && !mk) x = 8'h01;
      else if (lock && ad != 16'h0000) x = 8'h01;
      else if (run && g inside {8'h02, 8'h04, 8'h05}) x = 8'h05;
      else if ((ad == 16'h0100 && dt > 16'h0008) ||
               (g == 8'h06 && i inside {[1:5]} && dt > 16'h00FF)) x = 8'h04;
      else if (g == 8'h06 && i inside {[1:5]} && dt != 16'h0000)
        for (int j = 1; j < 6; j++) if (j != i && di[j] == dt) x = 8'h07;
      if (x == 8'h00) begin
        mem[ad] = dt;
        if (ad == 16'h0100) src = dt;
        if (g == 8'h06 && i inside {[1:5]}) di[i] = dt;
      end
    end
    if (x != 8'h00) {fl, q} = {1'b1, 16'h0000};
    return {fl, fn, x, q};
  endfunction
  task req(input logic [7:0] fn, input logic [15:0] ad, input logic wr, input logic [15:0] dt, nn);
    eq.push_back(model(fn, ad, wr, dt, nn));
    u_mst.send(fn, ad, wr, dt, nn);
  endtask
  always @(negedge clk_in) if (rv === 1'b1) begin
    e = eq.pop_front();
    check("code", {7'h00, e[23:16] != 8'h00, e[23:16]}, {7'h00, rx, rc});
    check("func", {8'h00, e[31:24] | (e[23:16] != 8'h00 ? 8'h80 : 8'h00)}, {8'h00, rf});
    if (e[32]) check("data", e[15:0], rd);
  end
  always @(negedge clk_in) begin
    if (fu === 1'b1) upd_seen++;
    if (cs === 1'b1) cmd_seen++;
  end
  task levels();
    repeat (3) u_mst.idle();
    @(negedge clk_in);
    check("cmd", {8'h00, cmdw[7:0]}, {8'h00, c});
    check("freq", freq, fs);
    check("updates", 16'(upd_exp), 16'(upd_seen));
    check("strobes", 16'(cmd_exp), 16'(cmd_seen));
    check("pending", 16'h0000, 16'(eq.size()));
    @(posedge clk_in);
  endtask
  task reset_dut();
    rst_in <= 1'b1;
    repeat (2) u_mst.idle();
    rst_in <= 1'b0;
    {src, cmdw, freq} = '0;
    di = '{default: 0};
  endtask
  task final_report();
    if (failures == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk_in);
    failures++;
    final_report();
  end
  initial begin
    void'($urandom(77));
    reset_dut();
    repeat (8) req(8'($urandom), 16'h5000, 1'b0, 16'($urandom), 16'h0001);
    req(8'h08, 16'($urandom), 1'b0, 16'($urandom), 16'h0001);
    req(8'h03, 16'h5000, 1'b0, 16'h0000, 16'h0010);
    req(8'h03, 16'h5000, 1'b0, 16'h0000, 16'h0011);
    lock <= 1'b1;
    u_mst.idle();
    repeat (4) req(8'h10, 16'h4000, 1'b1, 16'($urandom), 16'h0002);
    req(8'h03, 16'h4000, 1'b0, 16'h0000, 16'h0001);
    levels();
    lock <= 1'b0;
    mk <= 1'b1;
    u_mst.idle();
    // A setpoint is written before the link is selected as frequency source (source 9 refused, then 5), then written again.
    req(8'h06, 16'h4001, 1'b1, 16'h1234, 16'h0001);
    req(8'h06, 16'h0100, 1'b1, 16'h0009, 16'h0001);
    req(8'h06, 16'h0100, 1'b1, 16'h0005, 16'h0001);
    req(8'h10, 16'h4001, 1'b1, 16'($urandom), 16'h0002);
    req(8'h03, 16'h4001, 1'b0, 16'h0000, 16'h0001);
    levels();
    foreach (bad[j]) req(bad[j][23:16], bad[j][15:0], 1'b1, 16'h0001, 16'h0001);
    foreach (pool[j]) req(8'h06, pool[j], 1'b1, 16'(j), 16'h0001);
    repeat (10) begin
      // Drain the last answer first: the state word is sampled when it is answered.
      u_mst.idle();
      {lock, mk, run, flags, fault} <= 16'($urandom);
      u_mst.idle();
      repeat (6) begin
        k = $urandom_range(0, 3);
        req(fw[k], pool[$urandom_range(0, 14)], k > 1, 16'($urandom_range(0, 12)),
            16'($urandom_range(1, 17)));
      end
    end
    levels();
    reset_dut();
    levels();
    final_report();
  end
endmodule
`default_nettype wire
